// ### config_pin_pkg.sv
package config_pin_pkg;

    // function codes held in the configuration memory field
    typedef enum logic [4:0] {
        FN_TRI_STATE    = 5'h00,
        FN_DRIVE_HIGH   = 5'h01,
        FN_DRIVE_LOW    = 5'h02,
        FN_POWER_ENABLE = 5'h03,
        FN_SLEEP_IND    = 5'h04,
        FN_CLK_FAST     = 5'h05,
        FN_CLK_MID      = 5'h06,
        FN_CLK_SLOW     = 5'h07,
        FN_GPIO         = 5'h08,
        FN_CHARGER      = 5'h09,
        FN_CHARGER_N    = 5'h0a,
        FN_BB_WRITE     = 5'h0b,
        FN_BB_READ      = 5'h0c,
        FN_TX_EMPTY     = 5'h0d,
        FN_RX_FULL      = 5'h0e,
        FN_BUS_POWER    = 5'h0f,
        FN_TIMESTAMP    = 5'h10,
        FN_STAY_AWAKE   = 5'h11
    } pin_function_t;

    // configuration latch states, gray along the path
    typedef enum logic [1:0] {
        ST_WAIT_CFG = 2'b00,
        ST_RUN      = 2'b01
    } cfg_state_t;

    // rates, in hertz
    localparam longint SYS_CLOCK_HZ = 100_000_000;
    localparam longint REF_CLOCK_HZ = 48_000_000;
    localparam int     ACC_WIDTH    = 16;
    // reference tick: accumulator step for a 48 MHz tick rate
    localparam longint REF_STEP_L   =
        (REF_CLOCK_HZ * (64'd1 << ACC_WIDTH)) / SYS_CLOCK_HZ;
    localparam logic [ACC_WIDTH-1:0] REF_STEP = REF_STEP_L[ACC_WIDTH-1:0];
    localparam logic [ACC_WIDTH-1:0] ACC_RESET = 16'h0000;

    // tick counter bits carrying each pin clock
    localparam int DIV_WIDTH = 3;
    localparam int BIT_FAST  = 0;
    localparam int BIT_MID   = 1;
    localparam int BIT_SLOW  = 2;
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 3'h0;

    // device events and status from the rest of the bridge
    typedef struct packed {
        logic usb_configured;
        logic usb_suspend;
        logic usb_connected;
        logic charger_detected;
        logic bb_write_strobe_n;
        logic bb_read_strobe_n;
        logic tx_buffer_empty;
        logic rx_buffer_full;
        logic sof_received;
        logic gpio_out;
        logic gpio_oe;
    } core_status_t;

    // configurable pin drive
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_down;
    } pin_drive_t;

endpackage

// ### config_pin_function_select.sv
`timescale 1ns/1ps

module config_pin_function_select (
    input  wire logic                        i_clock,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_cfg_valid,
    input  wire logic [4:0]                  i_cfg_function,
    input  wire logic                        i_cfg_pull_down_suspend,
    input  wire config_pin_pkg::core_status_t i_status,
    input  wire logic                        i_config_pin0,
    input  wire logic                        i_sda,
    input  wire logic                        i_scl,
    input  wire logic                        i_sda_pull_low,
    output logic                             o_config_pin0,
    output logic                             o_config_pin0_oe,
    output logic                             o_config_pin0_pull_up,
    output logic                             o_config_pin0_pull_down,
    output logic                             o_sda,
    output logic                             o_sda_oe,
    output logic                             o_scl_oe,
    output logic                             o_i2c_pull_down,
    output logic                             o_sda_in,
    output logic                             o_scl_in,
    output logic                             o_gpio_in,
    output logic                             o_bus_power_present,
    output logic                             o_block_suspend,
    output logic                             o_cfg_loaded
);
    import config_pin_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    // whole module state
    typedef struct packed {
        cfg_state_t              state;
        pin_function_t           func;
        logic                    pull_down_opt;
        logic                    pin_meta;
        logic                    pin_sync;
        logic                    sda_meta;
        logic                    sda_sync;
        logic                    scl_meta;
        logic                    scl_sync;
        logic [ACC_WIDTH-1:0]    acc;
        logic [DIV_WIDTH-1:0]    div;
        logic                    stamp;
        pin_drive_t              pin;
        logic                    sda_oe;
        logic                    i2c_pull_down;
        logic                    gpio_in;
        logic                    bus_power;
        logic                    block_suspend;
    } state_t;

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////////////

    // map a raw code to a known function, unknown codes release the pin
    function automatic pin_function_t decode_function(input logic [4:0] c);
        pin_function_t f;
        f = FN_TRI_STATE;
        case (c)
            FN_TRI_STATE,
            FN_DRIVE_HIGH,
            FN_DRIVE_LOW,
            FN_POWER_ENABLE,
            FN_SLEEP_IND,
            FN_CLK_FAST,
            FN_CLK_MID,
            FN_CLK_SLOW,
            FN_GPIO,
            FN_CHARGER,
            FN_CHARGER_N,
            FN_BB_WRITE,
            FN_BB_READ,
            FN_TX_EMPTY,
            FN_RX_FULL,
            FN_BUS_POWER,
            FN_TIMESTAMP,
            FN_STAY_AWAKE: f = pin_function_t'(c);
            default:       f = FN_TRI_STATE;
        endcase
        return f;
    endfunction

    // functions in which the pin is an input
    function automatic logic is_input_fn(input pin_function_t f,
                                         input logic gpio_oe);
        logic r;
        r = 1'b0;
        case (f)
            FN_TRI_STATE,
            FN_BUS_POWER,
            FN_STAY_AWAKE: r = 1'b1;
            FN_GPIO:       r = ~gpio_oe;
            default:       r = 1'b0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    // next-state logic
    always_comb begin
        logic                 suspend;
        logic                 tick;
        logic [ACC_WIDTH:0]   sum;
        logic                 pulls_low;
        pin_drive_t           drv;
        state_next = state_reg;
        suspend    = i_status.usb_suspend;
        sum        = {1'b0, state_reg.acc} + {1'b0, REF_STEP};
        tick       = sum[ACC_WIDTH];
        pulls_low  = state_reg.pull_down_opt & suspend;
        drv        = '0;

        // two-stage synchronisers for pin inputs
        // configurable pin
        state_next.pin_meta = i_config_pin0;
        state_next.pin_sync = state_reg.pin_meta;
        // i2c data line
        state_next.sda_meta = i_sda;
        state_next.sda_sync = state_reg.sda_meta;
        // i2c clock line
        state_next.scl_meta = i_scl;
        state_next.scl_sync = state_reg.scl_meta;

        // function code captured once, from memory only
        case (state_reg.state)
            ST_WAIT_CFG: begin
                if (i_cfg_valid) begin
                    state_next.func = decode_function(i_cfg_function);
                    state_next.pull_down_opt = i_cfg_pull_down_suspend;
                    state_next.state = ST_RUN;
                end
            end
            ST_RUN:  state_next.state = ST_RUN;
            default: state_next.state = ST_WAIT_CFG;
        endcase

        // 48 mhz reference tick divided into the pin clocks
        state_next.acc = sum[ACC_WIDTH-1:0];
        if (suspend) begin
            state_next.div = DIV_RESET;
        end else if (tick) begin
            state_next.div = state_reg.div + 3'h1;
        end

        // start-of-frame toggle
        if (i_status.sof_received) begin
            state_next.stamp = ~state_reg.stamp;
        end

        // pin drive per function
        case (state_reg.func)
            // released pin
            FN_TRI_STATE: begin
                drv.oe  = 1'b0;
                drv.out = 1'b0;
            end
            // constant levels
            FN_DRIVE_HIGH: begin
                drv.oe  = 1'b1;
                drv.out = 1'b1;
            end
            FN_DRIVE_LOW: begin
                drv.oe  = 1'b1;
                drv.out = 1'b0;
            end
            // power switch control, active low
            FN_POWER_ENABLE: begin
                drv.oe  = 1'b1;
                drv.out = ~(i_status.usb_configured & ~suspend);
            end
            // sleep indication, low in suspend
            FN_SLEEP_IND: begin
                drv.oe  = 1'b1;
                drv.out = ~suspend;
            end
            // pin clocks from the divider bits
            FN_CLK_FAST: begin
                drv.oe  = 1'b1;
                drv.out = state_reg.div[BIT_FAST] & ~suspend;
            end
            FN_CLK_MID: begin
                drv.oe  = 1'b1;
                drv.out = state_reg.div[BIT_MID] & ~suspend;
            end
            FN_CLK_SLOW: begin
                drv.oe  = 1'b1;
                drv.out = state_reg.div[BIT_SLOW] & ~suspend;
            end
            // host bit-bang bit
            FN_GPIO: begin
                drv.oe  = i_status.gpio_oe;
                drv.out = i_status.gpio_out;
            end
            // charger seen, driven both ways
            FN_CHARGER: begin
                drv.oe  = 1'b1;
                drv.out = i_status.charger_detected;
            end
            // inverse charger, only ever pulls low
            FN_CHARGER_N: begin
                drv.oe  = i_status.charger_detected;
                drv.out = 1'b0;
            end
            // bit-bang strobes, already active low
            FN_BB_WRITE: begin
                drv.oe  = 1'b1;
                drv.out = i_status.bb_write_strobe_n;
            end
            FN_BB_READ: begin
                drv.oe  = 1'b1;
                drv.out = i_status.bb_read_strobe_n;
            end
            // buffer flags turned active low
            FN_TX_EMPTY: begin
                drv.oe  = 1'b1;
                drv.out = ~i_status.tx_buffer_empty;
            end
            FN_RX_FULL: begin
                drv.oe  = 1'b1;
                drv.out = ~i_status.rx_buffer_full;
            end
            // start-of-frame toggle, new level at once
            FN_TIMESTAMP: begin
                drv.oe  = 1'b1;
                drv.out = state_next.stamp;
            end
            // input functions leave the pin to the board
            FN_BUS_POWER,
            FN_STAY_AWAKE: begin
                drv.oe  = 1'b0;
                drv.out = 1'b0;
            end
            // unknown code leaves the pin released
            default: begin
                drv.oe  = 1'b0;
                drv.out = 1'b0;
            end
        endcase

        // pin stays released until the function is known
        if (state_reg.state != ST_RUN) begin
            drv.oe  = 1'b0;
            drv.out = 1'b0;
        end

        // weak pulls on an input pin
        if (is_input_fn(state_reg.func, i_status.gpio_oe) ||
            state_reg.state != ST_RUN) begin
            drv.pull_up   = ~pulls_low;
            drv.pull_down = pulls_low;
        end

        // registered drive for the pin
        state_next.pin = drv;

        // readback of the synchronised pin, in every mode
        state_next.gpio_in = state_reg.pin_sync;

        // bus power present only in its own mode
        state_next.bus_power = (state_reg.func == FN_BUS_POWER) &
                               state_reg.pin_sync;

        // low pin keeps the bridge awake only while unplugged
        state_next.block_suspend = (state_reg.func == FN_STAY_AWAKE) &
                                   ~state_reg.pin_sync &
                                   ~i_status.usb_connected;

        // i2c: data open drain pull only, clock never driven
        state_next.sda_oe = i_sda_pull_low;

        // suspend pulls on the i2c lines follow the pin option
        state_next.i2c_pull_down = pulls_low;
    end

    ////////////////////////////////////////////////////////////////////////

    // state register, cleared by the reset input
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // enums and counters back to their idle codes
            state_reg       <= '0;
            state_reg.state <= ST_WAIT_CFG;
            state_reg.func  <= FN_TRI_STATE;
            state_reg.acc   <= ACC_RESET;
            state_reg.div   <= DIV_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // outputs straight from the state register, except o_sda and o_scl_oe tied low
    // configurable pin drive and pulls
    assign o_config_pin0           = state_reg.pin.out;
    assign o_config_pin0_oe        = state_reg.pin.oe;
    assign o_config_pin0_pull_up   = state_reg.pin.pull_up;
    assign o_config_pin0_pull_down = state_reg.pin.pull_down;

    // i2c lines: data only pulls low, clock never driven
    assign o_sda                   = 1'b0;
    assign o_sda_oe                = state_reg.sda_oe;
    assign o_scl_oe                = 1'b0;
    assign o_i2c_pull_down         = state_reg.i2c_pull_down;

    // synchronised inputs and status
    assign o_sda_in                = state_reg.sda_sync;
    assign o_scl_in                = state_reg.scl_sync;
    assign o_gpio_in               = state_reg.gpio_in;
    assign o_bus_power_present     = state_reg.bus_power;
    assign o_block_suspend         = state_reg.block_suspend;
    assign o_cfg_loaded            = state_reg.state[0];

endmodule

// ### config_pin_props.sv
`timescale 1ns/1ps

// checks the pin drive against the latched function code
module config_pin_props (
    input wire logic                         i_clock,
    input wire logic                         i_rst_n,
    input wire logic                         i_cfg_valid,
    input wire logic [4:0]                   i_cfg_function,
    input wire logic                         i_cfg_pull_down_suspend,
    input wire config_pin_pkg::core_status_t i_status,
    input wire logic                         o_config_pin0,
    input wire logic                         o_config_pin0_oe,
    input wire logic                         o_config_pin0_pull_up,
    input wire logic                         o_config_pin0_pull_down,
    input wire logic                         o_sda,
    input wire logic                         o_scl_oe,
    input wire logic                         o_cfg_loaded
);
    import config_pin_pkg::*;

    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    logic [4:0] fn_reg;
    logic       opt_reg;
    logic [1:0] run_reg;
    logic       run;

    ////////////////////////////////////////////////////////////////////////
    // copy of the taken code; run marks the pin as settled
    assign run = run_reg[1];
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fn_reg <= 5'h00;
            opt_reg <= 1'h0;
            run_reg <= 2'h0;
        end else begin
            if (i_cfg_valid && !o_cfg_loaded) begin
                fn_reg <= i_cfg_function;
                opt_reg <= i_cfg_pull_down_suspend;
            end
            run_reg <= {run_reg[0], o_cfg_loaded};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    scl_undriven_a: assert property (!o_scl_oe && !o_sda)
        else $error("scl driven or sda driven high");
    load_hold_a: assert property (o_cfg_loaded |=> o_cfg_loaded)
        else $error("loaded flag dropped");
    static_level_a: assert property (run && fn_reg inside {5'h01, 5'h02}
        |-> o_config_pin0_oe && (o_config_pin0 == (fn_reg == 5'h01)))
        else $error("static level wrong");
    pin_release_a: assert property (run && (fn_reg == 5'h00
        || fn_reg > 5'h11) |-> !o_config_pin0_oe)
        else $error("pin driven when released");
    power_enable_a: assert property (run && fn_reg == FN_POWER_ENABLE
        |-> o_config_pin0_oe && o_config_pin0 == !($past(
        i_status.usb_configured) && !$past(i_status.usb_suspend)))
        else $error("power enable level wrong");
    charger_high_a: assert property (run && fn_reg == FN_CHARGER
        |-> o_config_pin0_oe && o_config_pin0 == $past(
        i_status.charger_detected))
        else $error("charger level wrong");
    charger_drain_a: assert property (run && fn_reg == FN_CHARGER_N
        |-> !o_config_pin0 && o_config_pin0_oe == $past(
        i_status.charger_detected))
        else $error("open drain charger wrong");
    strobe_flag_a: assert property (run
        && fn_reg inside {[5'h0b:5'h0e]} |-> o_config_pin0_oe
        && o_config_pin0 == (fn_reg == 5'h0b ? $past(
        i_status.bb_write_strobe_n) : fn_reg == 5'h0c ? $past(
        i_status.bb_read_strobe_n) : fn_reg == 5'h0d ? !$past(
        i_status.tx_buffer_empty) : !$past(i_status.rx_buffer_full)))
        else $error("strobe or flag level wrong");
    clock_stop_a: assert property (run && fn_reg inside {[5'h05:5'h07]}
        && $past(i_status.usb_suspend) |-> !o_config_pin0)
        else $error("clock runs in suspend");
    stamp_toggle_a: assert property (run && $past(run)
        && fn_reg == FN_TIMESTAMP |-> o_config_pin0 == ($past(
        o_config_pin0) ^ $past(i_status.sof_received)))
        else $error("timestamp toggle wrong");
    suspend_pull_a: assert property (run && fn_reg == FN_TRI_STATE
        |-> o_config_pin0_pull_down == ($past(i_status.usb_suspend)
        && opt_reg) && o_config_pin0_pull_up != o_config_pin0_pull_down)
        else $error("input pull wrong");
endmodule

bind config_pin_function_select config_pin_props config_pin_props_inst (.*);

// ### config_pin_partner.sv
`timescale 1ns/1ps

// board logic on the pin and the bus master on the i2c lines
module config_pin_partner (
    input  wire logic i_clock,
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe,
    input  wire logic i_pin_pu,
    input  wire logic i_pin_pd,
    input  wire logic i_board_en,
    input  wire logic i_board_val,
    input  wire logic i_sda_oe,
    input  wire logic i_master_sda_low,
    input  wire logic i_master_run,
    output logic      o_pin_wire,
    output logic      o_sda_wire,
    output logic      o_scl_wire
);
    logic       last_reg;
    logic [3:0] scl_reg;

    // pin: drivers, then weak pulls, else drifts off its last level
    always_comb begin
        if (i_pin_oe) o_pin_wire = i_pin_out;
        else if (i_board_en) o_pin_wire = i_board_val;
        else if (i_pin_pu || i_pin_pd) o_pin_wire = i_pin_pu;
        else o_pin_wire = ~last_reg;
    end
    // sda pulled up, low if either side pulls
    assign o_sda_wire = !(i_sda_oe || i_master_sda_low);
    // master clock idles high, runs only while the master is busy
    assign o_scl_wire = scl_reg[3];
    always @(posedge i_clock) begin
        last_reg <= o_pin_wire;
        if (i_master_run) begin
            scl_reg <= scl_reg + 4'h1;
        end else begin
            scl_reg <= 4'h8;
        end
    end
    initial begin
        last_reg = 1'b0;
        scl_reg = 4'h8;
    end
endmodule

// ### config_pin_function_select_tb_top.sv
`timescale 1ns/1ps

module config_pin_function_select_tb_top;
    import config_pin_pkg::*;

    typedef struct packed {
        logic [4:0]  fn;
        logic [10:0] st;
        logic [1:0]  ex;
    } row_t;
    // code, status, expected {out, oe}
    localparam row_t ROWS [19] = '{
        '{5'h00, 11'h060, 2'h0}, '{5'h01, 11'h060, 2'h3},
        '{5'h02, 11'h060, 2'h1}, '{5'h03, 11'h460, 2'h1},
        '{5'h03, 11'h660, 2'h3}, '{5'h03, 11'h060, 2'h3},
        '{5'h04, 11'h260, 2'h1}, '{5'h04, 11'h060, 2'h3},
        '{5'h09, 11'h0e0, 2'h3}, '{5'h09, 11'h060, 2'h1},
        '{5'h0a, 11'h0e0, 2'h1}, '{5'h0a, 11'h060, 2'h0},
        '{5'h0b, 11'h020, 2'h1}, '{5'h0c, 11'h040, 2'h1},
        '{5'h0d, 11'h070, 2'h1}, '{5'h0e, 11'h060, 2'h3},
        '{5'h08, 11'h063, 2'h3}, '{5'h1f, 11'h060, 2'h0},
        '{5'h12, 11'h060, 2'h0}};

    logic clock, rst_n, cfg_valid, opt, board_en, board_val, m_low, sda_pl;
    logic pin, pin_oe, pin_pu, pin_pd, sda_o, sda_oe, scl_oe, i2c_pd;
    logic sda_in, scl_in, gpio_in, bus_pwr, blk_susp, loaded, prev;
    logic pin_w, sda_w, scl_w;
    logic [4:0]   cfg_fn;
    logic [1:0]   scl_h;
    logic         m_run;
    core_status_t status;
    int bad_count, tests_run, cycles, n;

    config_pin_function_select config_pin_function_select_inst (
        .i_clock(clock), .i_rst_n(rst_n), .i_cfg_valid(cfg_valid),
        .i_cfg_function(cfg_fn), .i_cfg_pull_down_suspend(opt),
        .i_status(status), .i_config_pin0(pin_w), .i_sda(sda_w),
        .i_scl(scl_w), .i_sda_pull_low(sda_pl), .o_config_pin0(pin),
        .o_config_pin0_oe(pin_oe), .o_config_pin0_pull_up(pin_pu),
        .o_config_pin0_pull_down(pin_pd), .o_sda(sda_o), .o_sda_oe(sda_oe),
        .o_scl_oe(scl_oe), .o_i2c_pull_down(i2c_pd), .o_sda_in(sda_in),
        .o_scl_in(scl_in), .o_gpio_in(gpio_in),
        .o_bus_power_present(bus_pwr), .o_block_suspend(blk_susp),
        .o_cfg_loaded(loaded));
    config_pin_partner config_pin_partner_inst (
        .i_clock(clock), .i_pin_out(pin), .i_pin_oe(pin_oe),
        .i_pin_pu(pin_pu), .i_pin_pd(pin_pd), .i_board_en(board_en),
        .i_board_val(board_val), .i_sda_oe(sda_oe), .i_master_sda_low(m_low),
        .i_master_run(m_run), .o_pin_wire(pin_w), .o_sda_wire(sda_w),
        .o_scl_wire(scl_w));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_n(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, lo);
        end
    endtask
    task automatic ticks(input int k);
        repeat (k) @(negedge clock);
    endtask
    // reset for 16 cycles, then offer the code from config memory
    task automatic load(input logic [4:0] fn, input logic o);
        rst_n = 1'b0;
        cfg_valid = 1'b0;
        ticks(16);
        rst_n = 1'b1;
        cfg_fn = fn;
        opt = o;
        cfg_valid = 1'b1;
        ticks(4);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, cfg_valid, opt, board_en, board_val, m_low, sda_pl} = '0;
        cfg_fn = 5'h00;
        m_run = 1'b0;
        status = core_status_t'(11'h060);
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        ticks(16);
        check(pin_oe | pin_pu | loaded, 1'h0);
        $display("reset done");
        foreach (ROWS[i]) begin
            status = core_status_t'(ROWS[i].st);
            load(ROWS[i].fn, 1'h0);
            check(pin_oe, ROWS[i].ex[0]);
            if (ROWS[i].ex[0]) check(pin, ROWS[i].ex[1]);
            $display("row %0d done", i);
        end
        // later code ignored until reset, reset releases pin
        load(5'h01, 1'h0);
        cfg_fn = 5'h02;
        ticks(4);
        check(pin, 1'h1);
        check(loaded, 1'h1);
        rst_n = 1'b0;
        ticks(1);
        check(pin_oe, 1'h0);
        $display("hold done");
        // pin clock rate, then stopped in suspend
        for (int k = 0; k < 3; k++) begin
            status = core_status_t'(11'h460);
            load(5'(k + 5), 1'h0);
            n = 0;
            repeat (1000) begin
                prev = pin;
                @(negedge clock);
                n += int'(pin === 1'b1 && prev === 1'b0);
            end
            check_n(n, (240 >> k) - 2, (240 >> k) + 2);
            status.usb_suspend = 1'b1;
            ticks(3);
            n = 0;
            repeat (200) begin
                @(negedge clock);
                n += int'(pin !== 1'b0);
            end
            check_n(n, 0, 0);
        end
        $display("clocks done");
        // start-of-frame toggles, single pulses
        status = core_status_t'(11'h460);
        load(5'h10, 1'h0);
        prev = pin;
        for (int j = 1; j < 4; j++) begin
            status.sof_received = 1'b1;
            ticks(1);
            status.sof_received = 1'b0;
            ticks(1);
            check(pin, prev ^ j[0]);
        end
        // two pulses back to back toggle twice
        status.sof_received = 1'b1;
        ticks(2);
        status.sof_received = 1'b0;
        ticks(1);
        check(pin, ~prev);
        $display("stamp done");
        // pin as input: bus power, stay awake, general purpose
        status = core_status_t'(11'h060);
        board_en = 1'b1;
        board_val = 1'b1;
        load(5'h0f, 1'h0);
        ticks(4);
        check(bus_pwr, 1'h1);
        board_val = 1'b0;
        ticks(6);
        check(bus_pwr, 1'h0);
        load(5'h11, 1'h0);
        ticks(4);
        check(blk_susp, 1'h1);
        status.usb_connected = 1'b1;
        ticks(3);
        check(blk_susp, 1'h0);
        status = core_status_t'(11'h060);
        board_val = 1'b1;
        load(5'h08, 1'h0);
        ticks(4);
        check(gpio_in, 1'h1);
        board_en = 1'b0;
        $display("inputs done");
        // weak pulls flip low in suspend when the option is set
        status = core_status_t'(11'h260);
        load(5'h00, 1'h1);
        check(pin_pd & i2c_pd & !pin_pu, 1'h1);
        status.usb_suspend = 1'b0;
        ticks(2);
        check(pin_pu & !pin_pd, 1'h1);
        status = core_status_t'(11'h660);
        load(5'h03, 1'h1);
        check(pin, 1'h1);
        $display("pulls done");
        // data line open drain both ways
        sda_pl = 1'b1;
        ticks(2);
        check(sda_w | !sda_oe, 1'h0);
        sda_pl = 1'b0;
        m_low = 1'b1;
        ticks(4);
        check(sda_in | sda_oe, 1'h0);
        m_low = 1'b0;
        ticks(3);
        check(sda_in, 1'h1);
        // idle master clock stays high, running clock seen two cycles late
        check(scl_in, 1'h1);
        scl_h = 2'h3;
        m_run = 1'b1;
        repeat (40) begin
            scl_h = {scl_h[0], scl_w};
            @(negedge clock);
            check(scl_in, scl_h[1]);
        end
        m_run = 1'b0;
        $display("i2c done");
        wrap_up();
    end
endmodule
